//--- dv/suart_peer.sv
`timescale 1ns/100ps
`default_nettype none
module suart_peer (
  input  wire logic clk_i,
  input  wire logic line_i,
  output var  logic rx_o
);
  initial rx_o = 1'b1;
  // frame is start, data, parity, stops, first bit in f[0]
  task automatic send(input logic [12:0] f, input int n, input int bc);
    for (int i = 0; i < n; i++) begin
      rx_o <= f[i];
      repeat (bc) @(posedge clk_i);
    end
    rx_o <= 1'b1;
    @(posedge clk_i);
  endtask
  task automatic recv(input int n, input int bc, output logic [12:0] f);
    int t;
    f = '1;
    t = 0;
    while (line_i === 1'b1 && t < 40000) begin
      @(posedge clk_i);
      t++;
    end
    // centre sampling tolerates a cycle or two of skew
    repeat (bc / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      f[i] = line_i;
      repeat (bc) @(posedge clk_i);
    end
  endtask
endmodule // suart_peer
`default_nettype wire

//--- dv/suart_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module suart_top_sva (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        serial_rx_pin_i,
  input wire logic        serial_tx_pin_o,
  input wire logic        serial_tx_pin_oe_o,
  input wire logic        counter_port_pin_i,
  input wire logic        counter_input_o,
  input wire logic        tx_irq_o,
  input wire logic        rx_irq_o
);
  logic       irs_q, route_q, txw_q;
  logic [7:0] low_q;
  wire        wr   = psel_i && penable_i && pready_o && pwrite_i;
  wire        line = serial_tx_pin_oe_o ? serial_tx_pin_o : 1'b1;
  wire        src  = route_q ? serial_rx_pin_i : counter_port_pin_i;
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irs_q   <= 1'b0;
      route_q <= 1'b0;
      txw_q   <= 1'b0;
      low_q   <= 8'h00;
    end else begin
      if (wr && paddr_i == 12'h018) begin
        irs_q   <= pwdata_i[0];
        route_q <= pwdata_i[5];
      end
      if (wr && paddr_i == 12'h000)
        txw_q <= 1'b1;
      // saturate so a long break cannot wrap
      low_q <= line ? 8'h00 : ((low_q == 8'hff) ? low_q : low_q + 8'h01);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_RESET_IDLE: assert property ($rose(reset_n_i) |-> serial_tx_pin_o && !serial_tx_pin_oe_o)
    else $error("tx pin not idle after reset");
  AST_BIT_MIN: assert property ($rose(line) |-> low_q >= 8'h10)
    else $error("low run shorter than one bit");
  AST_NO_DATA_IDLE: assert property (!txw_q |-> line)
    else $error("tx line moved with no data written");
  AST_RX_IRQ_PULSE: assert property (rx_irq_o |=> !rx_irq_o)
    else $error("rx irq longer than one cycle");
  AST_TX_IRQ_PULSE: assert property (tx_irq_o |=> !tx_irq_o)
    else $error("tx irq longer than one cycle");
  AST_TX_DONE_HIGH: assert property (tx_irq_o && irs_q |-> line)
    else $error("end irq while line low");
  AST_ROUTE: assert property (!$rose(reset_n_i) |-> counter_input_o == $past(src))
    else $error("counter input routed wrong");
  AST_PREADY_WAIT: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
    else $error("bus answer timing wrong");
  COV_RX: cover property (rx_irq_o);
  COV_TX_END: cover property (tx_irq_o && irs_q);
  COV_ROUTE: cover property (route_q && counter_input_o);
endmodule // suart_top_sva
`default_nettype wire

//--- dv/suart_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module suart_top_tb;
  typedef struct packed {
    logic [2:0] m;
    logic       pe, ev, two, msb;
    logic [8:0] d, x;
  } suart_row_t;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        sclk = 1'b0, cport = 1'b0, pready, pslverr, rxd, txd, txoe, cin, txirq, rxirq, slv;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [12:0] f, g;
  int          err_total = 0, comparisons = 0, ntx = 0, nrx = 0, n, a;
  wire         line = txoe ? txd : 1'b1;
  suart_row_t  rows [5] = '{'{3'h4, 0, 0, 0, 0, 9'h1d5, 9'h055}, '{3'h5, 1, 0, 1, 0, 9'h0a6, 9'h0a6},
                            '{3'h5, 1, 1, 0, 1, 9'h0c1, 9'h0c1}, '{3'h6, 1, 1, 1, 0, 9'h1a5, 9'h1a5},
                            '{3'h6, 1, 0, 0, 0, 9'h103, 9'h103}};
  always #5 clk = ~clk;
  always @(posedge clk) sclk <= ~sclk;
  always @(posedge clk) begin
    ntx += (txirq === 1'b1);
    nrx += (rxirq === 1'b1);
  end
  suart_top u_suart_top (.clk_i(clk), .reset_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .serial_rx_pin_i(rxd), .serial_tx_pin_o(txd), .serial_tx_pin_oe_o(txoe), .serial_clock_pin_i(sclk),
    .counter_port_pin_i(cport), .counter_input_o(cin), .tx_irq_o(txirq), .rx_irq_o(rxirq));
  suart_peer u_peer (.clk_i(clk), .line_i(line), .rx_o(rxd));
  task automatic chk(input logic [15:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int t;
    t = 0;
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    slv = (pslverr === 1'b1);
    r = prdata;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
    chk(16'(t < 20), 16'h1, "bus answer");
  endtask
  function automatic logic [12:0] frame(suart_row_t w, output int n);
    int   nb;
    logic p;
    frame = '1;
    nb = (w.m == 3'h4) ? 7 : (w.m == 3'h5) ? 8 : 9;
    p = ^w.x;
    frame[0] = 1'b0;
    for (int i = 0; i < nb; i++) frame[1+i] = w.msb ? w.x[nb-1-i] : w.x[i];
    n = nb + 1;
    if (w.pe) begin
      frame[n] = w.ev ? p : ~p;
      n++;
    end
    n += w.two ? 2 : 1;
  endfunction
  task automatic setup(suart_row_t w, logic ck, od, logic [1:0] pre, logic [7:0] sh, cb);
    apb(1, 12'h00c, {25'h0, w.pe, w.ev, w.two, ck, w.m});
    apb(1, 12'h010, {24'h0, w.msb, 1'b0, od, 3'h0, pre});
    apb(1, 12'h018, {24'h0, sh});
    apb(1, 12'h014, {24'h0, cb});
  endtask
  task automatic trip(suart_row_t w, int bc);
    int         b;
    logic [8:0] k;
    a = ntx;
    b = nrx;
    k = (w.m == 3'h4) ? 9'h07f : (w.m == 3'h5) ? 9'h0ff : 9'h1ff;
    f = frame(w, n);
    apb(1, 12'h000, {23'h0, w.d});
    u_peer.recv(n, bc, g);
    chk(g & ~(13'h1fff << n), f & ~(13'h1fff << n), "tx frame");
    u_peer.send(f, n, bc);
    repeat (4) @(posedge clk);
    apb(0, 12'h010, 0);
    chk(r[3], 1'b1, "shift empty");
    apb(0, 12'h014, 0);
    chk(r[3:0], 4'hf, "ctrl b flags");
    apb(0, 12'h004, 0);
    chk({r[15:12], r[8:0] & k}, {4'h0, w.x}, "rx data");
    chk(16'(ntx - a), 1, "tx irq");
    chk(16'(nrx - b), 1, "rx irq");
  endtask
  task automatic rx_err(logic [3:0] e);
    u_peer.send(f, n, 32);
    repeat (4) @(posedge clk);
    apb(0, 12'h004, 0);
    chk(r[15:12], e, "error flags");
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #800000;
    err_total++;
    $display("CHECK FAILED %0t watchdog", $time);
    finish_test;
  end
  initial begin
    repeat (3) @(posedge clk);
    chk({txd, txoe}, 2'b10, "reset pins");
    rst_n <= 1'b1;
    @(posedge clk);
    apb(0, 12'h00c, 0);
    chk(r[7:0], 8'h00, "mode reset");
    apb(0, 12'h010, 0);
    chk(r[7:0], 8'h08, "ctrl a reset");
    apb(0, 12'h014, 0);
    chk(r[7:0], 8'h02, "ctrl b reset");
    apb(0, 12'h01c, 0);
    chk(slv, 1'b1, "unmapped");
    $display("test reset done");
    apb(1, 12'h008, 1);
    foreach (rows[i]) begin
      setup(rows[i], 0, 0, 2'h0, {7'h0, i[0]}, 8'h05);
      trip(rows[i], 32);
    end
    $display("test table done");
    apb(1, 12'h008, 0);
    for (int c = 0; c < 4; c++) begin
      setup(rows[1], c == 3, 0, (c == 3) ? 2'h0 : 2'(c), 0, 8'h05);
      trip(rows[1], (c == 0) ? 16 : (c == 1) ? 128 : (c == 2) ? 512 : 32);
    end
    $display("test count source done");
    apb(1, 12'h008, 1);
    setup(rows[1], 0, 0, 2'h0, 0, 8'h05);
    f = frame(rows[1], n);
    f[9] = ~f[9];
    rx_err(4'b1100);
    f[9] = ~f[9];
    f[10] = 1'b0;
    rx_err(4'b1010);
    f[10] = 1'b1;
    u_peer.send(f, n, 32);
    a = nrx;
    rx_err(4'b1001);
    chk(16'(nrx - a), 0, "overrun irq");
    $display("test errors done");
    setup(rows[1], 0, 0, 2'h0, 0, 8'h01);
    a = nrx;
    u_peer.send(f, n, 32);
    apb(0, 12'h014, 0);
    chk({r[3], 15'(nrx - a)}, 0, "rx disabled");
    apb(1, 12'h014, 0);
    apb(1, 12'h000, {23'h0, rows[1].d});
    repeat (64) @(posedge clk);
    apb(0, 12'h014, 0);
    chk({line, r[1]}, 2'b10, "tx held");
    apb(1, 12'h014, 1);
    u_peer.recv(n, 32, g);
    chk(g, f, "tx after enable");
    $display("test enables done");
    setup(rows[1], 0, 1, 2'h0, 8'h20, 8'h05);
    chk({txoe, cin}, 2'b01, "open drain idle, route rx");
    cport <= 1'b1;
    apb(1, 12'h018, 0);
    chk(cin, 1'b1, "route port");
    cport <= 1'b0;
    repeat (3) @(posedge clk);
    chk(cin, 1'b0, "route port low");
    trip(rows[1], 32);
    setup(rows[1], 0, 0, 2'h0, 8'h04, 8'h04);
    apb(0, 12'h004, 0);
    apb(0, 12'h014, 0);
    chk(r[3:0], 4'h4, "continuous rx");
    $display("test pins done");
    finish_test;
  end
endmodule // suart_top_tb
bind suart_top suart_top_sva u_suart_top_sva (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .pready_o, .serial_rx_pin_i, .serial_tx_pin_o, .serial_tx_pin_oe_o, .counter_port_pin_i,
  .counter_input_o, .tx_irq_o, .rx_irq_o);
`default_nettype wire

//--- hw/suart_baud.v
`timescale 1ns/100ps
`default_nettype none
`include "suart_defs.vh"
module suart_baud #(
  parameter DIV_W = 8
) (
  input  wire             clk_i,
  input  wire             reset_n_i,
  input  wire             ext_sel_i,
  input  wire [1:0]       pre_sel_i,
  input  wire             ext_clk_i,
  input  wire [DIV_W-1:0] divisor_i,
  output reg              tick_o
);
  reg  [4:0]       pre_q;
  reg  [DIV_W-1:0] cnt_q;
  reg              ext_q;
  reg              src_en;
  always @* begin
    case (pre_sel_i)
      2'b00:   src_en = 1'b1;
      2'b01:   src_en = (pre_q[2:0] == `SUART_PRE8_LAST);
      2'b10:   src_en = (pre_q == `SUART_PRE32_LAST);
      default: src_en = 1'b0;
    endcase
    if (ext_sel_i) begin
      src_en = ext_clk_i & ~ext_q;
    end
  end
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_q  <= 5'h00;
      cnt_q  <= {DIV_W{1'b0}};
      ext_q  <= 1'b0;
      tick_o <= 1'b0;
    end else begin
      pre_q  <= pre_q + 5'h01;
      ext_q  <= ext_clk_i;
      tick_o <= 1'b0;
      if (src_en) begin
        if (cnt_q == {DIV_W{1'b0}}) begin
          cnt_q  <= divisor_i;
          tick_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(DIV_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // suart_baud
`default_nettype wire

//--- hw/suart_defs.vh
// Contract
// - frame is one start bit then 7, 8 or 9 character bits
// - optional parity bit after character bits, odd or even
// - frame ends with one or two stop bits
// - mode select 100b, 101b, 110b picks 7, 8, 9 bit characters
// - bit rate is count source over 16 times divisor plus one
// - internal count source is clock undivided, divided by 8 or 32
// - external mode counts serial clock pin, pin kept as input
// - transmit starts only with tx enable set and buffer holding data
// - receive starts only with rx enable set and start bit seen
// - irq source 0 raises tx interrupt when buffer moves to shifter
// - irq source 1 raises tx interrupt when shifter finishes frame
// - rx interrupt when finished character enters receive buffer
// - overrun when buffer unread as next frame reaches bit before last stop; code checks stop bit for one stop, last data or parity bit and first stop for two
// - on overrun buffer is undefined and rx interrupt flag unchanged
// - framing error when configured stop bits not detected
// - parity error when ones count disagrees with selected parity
// - error summary set on any overrun, framing or parity error
// - data uses bits 0-6, 0-7 or 0-8 by character length
// - bit order selectable only for 8-bit characters
// - tx line idles high, or released in open-drain mode
// - tx shift empty, tx buffer empty and rx complete flags readable
// - route select sends counter input to port pin or rx pin
// - continuous rx mode: reading rx buffer clears tx buffer empty flag
`ifndef SUART_DEFS_VH
`define SUART_DEFS_VH
`define SUART_TXB_OFS    12'h000
`define SUART_RXB_OFS    12'h004
`define SUART_BRG_OFS    12'h008
`define SUART_MODE_OFS   12'h00c
`define SUART_CTLA_OFS   12'h010
`define SUART_CTLB_OFS   12'h014
`define SUART_SHCTL_OFS  12'h018
`define SUART_MODE_RST   8'h00
`define SUART_CTLA_RST   8'h08
`define SUART_CTLB_RST   8'h02
`define SUART_SHCTL_RST  8'h00
`define SUART_SMD_7BIT   3'h4
`define SUART_SMD_8BIT   3'h5
`define SUART_SMD_9BIT   3'h6
`define SUART_OVERSAMPLE 4'hf
`define SUART_MID_TICK   4'h7
`define SUART_PRE8_LAST  5'h07
`define SUART_PRE32_LAST 5'h1f
// mode reg bits
`define SUART_M_CLOCK_SOURCE_DIRECTION    3
`define SUART_M_STOP_BIT_COUNT_SELECT     4
`define SUART_M_PRY      5
`define SUART_M_PARITY_ENABLE     6
// ctrl a bits
`define SUART_A_TX_SHIFT_EMPTY_FLAG    3
`define SUART_A_NCH      5
`define SUART_A_BIT_ORDER_SELECT    7
// ctrl b bits
`define SUART_B_TE       0
`define SUART_B_TI       1
`define SUART_B_RE       2
`define SUART_B_RI       3
// shared ctrl bits
`define SUART_S_IRS      0
`define SUART_S_RRM      2
`define SUART_S_CNTR     5
// rx buffer status bits
`define SUART_R_OER      12
`define SUART_R_FER      13
`define SUART_R_PER      14
`define SUART_R_SUM      15
`endif

//--- hw/suart_rx.v
`timescale 1ns/100ps
`default_nettype none
`include "suart_defs.vh"
module suart_rx (
  input  wire       clk_i,
  input  wire       reset_n_i,
  input  wire       tick_i,
  input  wire       enable_i,
  input  wire       rxd_i,
  input  wire [3:0] nbits_i,
  input  wire       par_en_i,
  input  wire       par_odd_i,
  input  wire       two_stop_i,
  input  wire       msb_first_i,
  output reg  [8:0] data_o,
  output reg        done_o,
  output reg        fer_o,
  output reg        per_o,
  output reg        near_end_o
);
  localparam S_IDLE  = 4'b0001;
  localparam S_START = 4'b0010;
  localparam S_BITS  = 4'b0100;
  localparam S_STOP  = 4'b1000;
  reg [3:0] st_q;
  reg [3:0] sub_q;
  reg [3:0] idx_q;
  reg [9:0] sh_q;
  reg       rx_q;
  reg       stop2_q;
  wire      mid = tick_i && (sub_q == `SUART_MID_TICK);
  wire [3:0] tot = nbits_i + {3'h0, par_en_i};
  wire [8:0] dmask = (nbits_i == 4'h7) ? 9'h07f : (nbits_i == 4'h8) ? 9'h0ff : 9'h1ff;
  wire [8:0] raw = sh_q[8:0] & dmask;
  wire [7:0] rev;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_rev
      assign rev[g] = raw[7-g];
    end
  endgenerate
  wire pbit = sh_q[nbits_i];
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= S_IDLE; sub_q <= 4'h0; idx_q <= 4'h0; sh_q <= 10'h000;
      rx_q <= 1'b1; stop2_q <= 1'b0; data_o <= 9'h000; done_o <= 1'b0;
      fer_o <= 1'b0; per_o <= 1'b0; near_end_o <= 1'b0;
    end else begin
      rx_q <= rxd_i;
      done_o <= 1'b0;
      near_end_o <= 1'b0;
      if (tick_i) begin
        sub_q <= sub_q + 4'h1;
      end
      case (st_q)
        S_IDLE: begin
          if (enable_i && rx_q && !rxd_i) begin
            st_q <= S_START;
            sub_q <= 4'h0;
          end
        end
        S_START: begin
          if (mid) begin
            st_q <= rxd_i ? S_IDLE : S_BITS;
            idx_q <= 4'h0;
          end
        end
        S_BITS: begin
          if (mid) begin
            sh_q[idx_q] <= rxd_i;
            idx_q <= idx_q + 4'h1;
            if (idx_q == tot - 4'h1) begin
              st_q <= S_STOP;
              stop2_q <= two_stop_i;
              near_end_o <= two_stop_i;
            end
          end
        end
        S_STOP: begin
          if (mid) begin
            if (!rxd_i) begin
              fer_o <= 1'b1;
            end
            if (stop2_q && rxd_i) begin
              stop2_q <= 1'b0;
              near_end_o <= 1'b1;
            end else begin
              st_q <= S_IDLE;
              done_o <= 1'b1;
              if (!stop2_q) begin
                fer_o <= !rxd_i;
              end
              per_o <= par_en_i && ((^raw ^ pbit) != par_odd_i);
              data_o <= (msb_first_i && nbits_i == 4'h8) ? {1'b0, rev} : raw;
            end
          end
          if (st_q == S_STOP && !mid && sub_q == 4'h0 && !stop2_q) begin
            fer_o <= fer_o;
          end
        end
        default: st_q <= S_IDLE;
      endcase
      if (st_q == S_START) begin
        fer_o <= 1'b0;
      end
    end
  end
endmodule // suart_rx
`default_nettype wire

//--- hw/suart_top.v
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "suart_defs.vh"
module suart_top (
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire        serial_rx_pin_i,
  output reg         serial_tx_pin_o,
  output reg         serial_tx_pin_oe_o,
  input  wire        serial_clock_pin_i,
  input  wire        counter_port_pin_i,
  output reg         counter_input_o,
  output reg         tx_irq_o,
  output reg         rx_irq_o
);
  localparam T_IDLE  = 3'b001;
  localparam T_SHIFT = 3'b010;
  localparam T_LOAD  = 3'b100;
  reg [8:0]  tx_buffer_reg_q;
  reg [15:0] rx_buffer_reg_q;
  reg [7:0]  baud_divisor_reg_q;
  reg [7:0]  serial_mode_reg_q;
  reg [7:0]  serial_control_reg_a_q;
  reg [7:0]  serial_control_reg_b_q;
  reg [7:0]  serial_shared_control_reg_q;
  reg [2:0]  tst_q;
  reg [11:0] tsh_q;
  reg [3:0]  tcnt_q;
  reg [3:0]  tsub_q;
  wire       tick;
  wire [8:0] rx_data;
  wire       rx_done;
  wire       rx_fer;
  wire       rx_per;
  wire       rx_near;
  reg        rx_pending_q;
  reg        ovr_q;
  wire [2:0] smd = serial_mode_reg_q[2:0];
  wire       uart_mode = (smd == `SUART_SMD_7BIT) || (smd == `SUART_SMD_8BIT) || (smd == `SUART_SMD_9BIT);
  wire [3:0] nbits = (smd == `SUART_SMD_7BIT) ? 4'h7 : (smd == `SUART_SMD_8BIT) ? 4'h8 : 4'h9;
  wire       par_en = serial_mode_reg_q[`SUART_M_PARITY_ENABLE];
  wire       par_odd = !serial_mode_reg_q[`SUART_M_PRY];
  wire       two_stop = serial_mode_reg_q[`SUART_M_STOP_BIT_COUNT_SELECT];
  wire       msb_first = serial_control_reg_a_q[`SUART_A_BIT_ORDER_SELECT] && (nbits == 4'h8);
  wire       wr = psel_i && penable_i && pwrite_i && pready_o;
  wire       rd = psel_i && penable_i && !pwrite_i && pready_o;
  wire       rd_rxb = rd && paddr_i == `SUART_RXB_OFS;
  wire       wr_txb = wr && paddr_i == `SUART_TXB_OFS;
  wire       ti = serial_control_reg_b_q[`SUART_B_TI];
  wire       te = serial_control_reg_b_q[`SUART_B_TE];
  wire       tdone = tst_q == T_SHIFT && tick && tsub_q == `SUART_OVERSAMPLE && tcnt_q == 4'h0;
  wire       tstart = (tst_q == T_IDLE || tdone) && uart_mode && te && !ti;
  // tx frame: start as lsb, then data, parity, stop bits
  reg  [8:0] tdata;
  reg        tpar;
  reg [11:0] tframe;
  reg [3:0]  tlen;
  integer    k;
  always @* begin
    tdata = tx_buffer_reg_q & ((nbits == 4'h7) ? 9'h07f : (nbits == 4'h8) ? 9'h0ff : 9'h1ff);
    if (msb_first) begin
      for (k = 0; k < 8; k = k + 1) begin
        tdata[k] = tx_buffer_reg_q[7-k];
      end
    end
    tpar = (^tdata) ^ par_odd;
    tframe = 12'hfff;
    tframe[0] = 1'b0;
    for (k = 0; k < 9; k = k + 1) begin
      if (k < nbits) begin
        tframe[k+1] = tdata[k];
      end
    end
    if (par_en) begin
      tframe[nbits+4'h1] = tpar;
    end
    tlen = 4'h1 + nbits + {3'h0, par_en} + {3'h0, two_stop};
  end
  suart_baud #(
    .DIV_W (8)
  ) u_baud (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ext_sel_i (serial_mode_reg_q[`SUART_M_CLOCK_SOURCE_DIRECTION]),
    .pre_sel_i (serial_control_reg_a_q[1:0]),
    .ext_clk_i (serial_clock_pin_i),
    .divisor_i (baud_divisor_reg_q),
    .tick_o    (tick)
  );
  suart_rx u_rx (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .tick_i      (tick),
    .enable_i    (serial_control_reg_b_q[`SUART_B_RE] && uart_mode),
    .rxd_i       (serial_rx_pin_i),
    .nbits_i     (nbits),
    .par_en_i    (par_en),
    .par_odd_i   (par_odd),
    .two_stop_i  (two_stop),
    .msb_first_i (msb_first),
    .data_o      (rx_data),
    .done_o      (rx_done),
    .fer_o       (rx_fer),
    .per_o       (rx_per),
    .near_end_o  (rx_near)
  );
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tst_q <= T_IDLE; tsh_q <= 12'hfff; tcnt_q <= 4'h0; tsub_q <= 4'h0;
      serial_tx_pin_o <= 1'b1; serial_tx_pin_oe_o <= 1'b0; tx_irq_o <= 1'b0;
    end else begin
      tx_irq_o <= 1'b0;
      if (tick) begin
        tsub_q <= tsub_q + 4'h1;
      end
      case (tst_q)
        T_IDLE: ;
        T_SHIFT: begin
          if (tick && tsub_q == `SUART_OVERSAMPLE) begin
            tsh_q <= {1'b1, tsh_q[11:1]};
            tcnt_q <= tcnt_q - 4'h1;
            if (tcnt_q == 4'h0) begin
              tst_q <= T_IDLE;
              tx_irq_o <= serial_shared_control_reg_q[`SUART_S_IRS];
            end
          end
        end
        default: tst_q <= T_IDLE;
      endcase
      if (tstart) begin
        tst_q <= T_SHIFT;
        tsh_q <= tframe;
        tcnt_q <= tlen;
        tsub_q <= 4'h0;
        // only set here, so an end-of-frame pulse in this cycle survives
        if (!serial_shared_control_reg_q[`SUART_S_IRS]) begin
          tx_irq_o <= 1'b1;
        end
      end
      serial_tx_pin_o <= (tst_q == T_SHIFT) ? tsh_q[0] : 1'b1;
      // open drain releases instead of driving high
      serial_tx_pin_oe_o <= uart_mode && !(serial_control_reg_a_q[`SUART_A_NCH] &&
                            ((tst_q == T_SHIFT) ? tsh_q[0] : 1'b1));
    end
  end
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_buffer_reg_q <= 9'h000; rx_buffer_reg_q <= 16'h0000; baud_divisor_reg_q <= 8'h00;
      serial_mode_reg_q <= `SUART_MODE_RST; serial_control_reg_a_q <= `SUART_CTLA_RST;
      serial_control_reg_b_q <= `SUART_CTLB_RST; serial_shared_control_reg_q <= `SUART_SHCTL_RST;
      rx_pending_q <= 1'b0; ovr_q <= 1'b0; rx_irq_o <= 1'b0; counter_input_o <= 1'b0;
      prdata_o <= 32'h0000_0000; pready_o <= 1'b0; pslverr_o <= 1'b0;
    end else begin
      rx_irq_o <= 1'b0;
      pready_o <= psel_i && !pready_o;
      pslverr_o <= 1'b0;
      counter_input_o <= serial_shared_control_reg_q[`SUART_S_CNTR] ? serial_rx_pin_i : counter_port_pin_i;
      if (wr) begin
        case (paddr_i)
          `SUART_TXB_OFS:   tx_buffer_reg_q <= pwdata_i[8:0];
          `SUART_BRG_OFS:   baud_divisor_reg_q <= pwdata_i[7:0];
          `SUART_MODE_OFS:  serial_mode_reg_q <= pwdata_i[7:0];
          `SUART_CTLA_OFS:  serial_control_reg_a_q <= {pwdata_i[7:4], 1'b0, pwdata_i[2:0]};
          `SUART_CTLB_OFS:  begin
            serial_control_reg_b_q[`SUART_B_TE] <= pwdata_i[`SUART_B_TE];
            serial_control_reg_b_q[`SUART_B_RE] <= pwdata_i[`SUART_B_RE];
          end
          `SUART_SHCTL_OFS: serial_shared_control_reg_q <= pwdata_i[7:0];
          `SUART_RXB_OFS:   ;
          default:          ;
        endcase
      end
      // status flag after the write, so a control write cannot hide it
      serial_control_reg_a_q[`SUART_A_TX_SHIFT_EMPTY_FLAG] <= (tst_q == T_IDLE) && !tstart;
      // decoded in setup so data and error stand with pready
      if (psel_i && !pready_o) begin
        case (paddr_i)
          `SUART_TXB_OFS:   prdata_o <= {23'h0, tx_buffer_reg_q};
          `SUART_RXB_OFS:   prdata_o <= {16'h0, rx_buffer_reg_q};
          `SUART_BRG_OFS:   prdata_o <= {24'h0, baud_divisor_reg_q};
          `SUART_MODE_OFS:  prdata_o <= {24'h0, serial_mode_reg_q};
          `SUART_CTLA_OFS:  prdata_o <= {24'h0, serial_control_reg_a_q};
          `SUART_CTLB_OFS:  prdata_o <= {24'h0, serial_control_reg_b_q};
          `SUART_SHCTL_OFS: prdata_o <= {24'h0, serial_shared_control_reg_q};
          default: begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b1;
          end
        endcase
      end
      // tx empty flag: write fills, load to shifter empties
      if (wr_txb || (rd_rxb && serial_shared_control_reg_q[`SUART_S_RRM])) begin
        serial_control_reg_b_q[`SUART_B_TI] <= 1'b0;
      end
      if (tstart) begin
        serial_control_reg_b_q[`SUART_B_TI] <= 1'b1;
      end
      if (rd_rxb) begin
        rx_pending_q <= 1'b0;
        serial_control_reg_b_q[`SUART_B_RI] <= 1'b0;
        rx_buffer_reg_q[`SUART_R_SUM:`SUART_R_OER] <= 4'h0;
      end
      if (rx_near && (rx_pending_q || serial_control_reg_b_q[`SUART_B_RI])) begin
        ovr_q <= 1'b1;
      end
      if (rx_done) begin
        // overrun leaves irq untouched; buffer treated as undefined
        if (ovr_q || ((rx_pending_q && !rd_rxb) && !two_stop)) begin
          rx_buffer_reg_q[`SUART_R_OER] <= 1'b1;
          rx_buffer_reg_q[`SUART_R_SUM] <= 1'b1;
        end else begin
          rx_buffer_reg_q[8:0] <= rx_data;
          rx_buffer_reg_q[`SUART_R_FER] <= rx_fer;
          rx_buffer_reg_q[`SUART_R_PER] <= rx_per;
          rx_buffer_reg_q[`SUART_R_SUM] <= rx_fer || rx_per;
          rx_pending_q <= 1'b1;
          serial_control_reg_b_q[`SUART_B_RI] <= 1'b1;
          rx_irq_o <= 1'b1;
        end
        ovr_q <= 1'b0;
      end
    end
  end
endmodule // suart_top
`default_nettype wire
